// >>> hw/loop_dac_fault_status.sv
// Operation
// - On-chip ADC stays disabled while its enable bit is 0; reset default off.
// - Reference power-down bit 1 turns internal reference off; default on.
// - With ADC on, alert enable 1 raises fault output when loop sense falls near 0.3 V.
// - Fault register is read-only; writes never alter it.
// - Fault bits 15..8 are the eight flags; bits 7..0 the ADC result.
// - Watchdog timeout sets SPI fault flag and raises the fault output.
// - SPI timeout forces alarm current when control bit 10 is 0.
// - Alarm current direction follows the sampled polarity pin.
// - Frame check error sets its flag and raises the fault output.
// - Loop current above programmed sets over flag and fault output.
// - Loop current below programmed sets under flag and fault output.
// - Over-140 flag sets above 140 C, clears only below 125 C.
// - ADC field encodes loop sense voltage as 2.5/256 V per code.
// - SPI alarm bit defaults 0; at 1 flag and alert set, no forcing.
`timescale 1ns/1ps
`default_nettype none
module loop_dac_fault_status (
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	// Control register write from the serial frame decoder
	input  wire logic        ctl_wr_i,
	input  wire logic [15:0] ctl_wdata_i,
	input  wire logic        fault_wr_i,
	input  wire logic [15:0] fault_wdata_i,
	// Events from the serial interface
	input  wire logic        spi_timeout_i,
	input  wire logic        frame_check_error_i,
	input  wire logic        valid_frame_i,
	// Analog comparators and ADC (asynchronous)
	input  wire logic        over_i,
	input  wire logic        under_i,
	input  wire logic        temp_hi140_i,
	input  wire logic        temp_lo125_i,
	input  wire logic        temp_hi100_i,
	input  wire logic        temp_lo85_i,
	input  wire logic [7:0]  loop_sense_voltage_i,
	input  wire logic        alarm_dir_i,
	output logic [15:0]      fault_status_o,
	output logic             fault_alert_o,
	output logic             adc_en_o,
	output logic             ref_pd_o,
	output logic             alarm_force_o,
	output logic             alarm_high_o
);
	logic [1:0] rst_sync_q;
	logic       rst_n;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	default clocking dflt_cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n);

	// Two-flop synchronisers for analog-side levels
	logic [6:0] async_m_q, async_s_q;
	logic [7:0] adc_m_q, adc_s_q, adc_p_q;
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			async_m_q <= 7'h00;
			async_s_q <= 7'h00;
			adc_m_q   <= 8'h00;
			adc_s_q   <= 8'h00;
			adc_p_q   <= 8'h00;
		end else begin
			async_m_q <= {over_i, under_i, temp_hi140_i, temp_lo125_i,
				temp_hi100_i, temp_lo85_i, alarm_dir_i};
			async_s_q <= async_m_q;
			adc_m_q   <= loop_sense_voltage_i;
			adc_s_q   <= adc_m_q;
			adc_p_q   <= adc_s_q;
		end
	end
	logic s_over, s_under, s_h140, s_l125, s_h100, s_l85, s_dir;
	assign {s_over, s_under, s_h140, s_l125, s_h100, s_l85, s_dir} = async_s_q;
	// Code word is not gray coded: use it only once two samples agree
	logic adc_stable;
	assign adc_stable = (adc_s_q == adc_p_q);

	loop_fault_pkg::ctl_bits_s ctl_q, ctl_d;
	always_comb begin
		ctl_d = ctl_q;
		if (ctl_wr_i) begin
			ctl_d.alarm_spi_off =
				ctl_wdata_i[loop_fault_pkg::CTL_ALARM_SPI_BIT];
			ctl_d.adc_en = ctl_wdata_i[loop_fault_pkg::CTL_ADC_EN_BIT];
			ctl_d.ref_pd = ctl_wdata_i[loop_fault_pkg::CTL_REF_PD_BIT];
			ctl_d.vlow_alert_en =
				ctl_wdata_i[loop_fault_pkg::CTL_VLOW_ALERT_BIT];
		end
	end

	loop_fault_pkg::fault_flags_s flg_q, flg_d;
	logic [7:0] adc_q, adc_d;
	logic       dir_q, dir_d;
	always_comb begin
		flg_d = flg_q;
		// Event flags stay until a valid frame; a new event wins the clear
		if (valid_frame_i) begin
			flg_d.spi_timeout = 1'b0;
			flg_d.frame_err   = 1'b0;
		end
		if (spi_timeout_i)
			flg_d.spi_timeout = 1'b1;
		if (frame_check_error_i)
			flg_d.frame_err = 1'b1;
		flg_d.over  = s_over;
		flg_d.under = s_under;
		// Hysteresis: set above upper trip, clear below lower
		if (s_h140)
			flg_d.t140 = 1'b1;
		else if (s_l125)
			flg_d.t140 = 1'b0;
		if (s_h100)
			flg_d.t100 = 1'b1;
		else if (s_l85)
			flg_d.t100 = 1'b0;
		// Voltage compare needs fresh ADC data
		if (ctl_q.adc_en && adc_stable) begin
			flg_d.v6  = (adc_s_q <= loop_fault_pkg::VLOW_6V_CODE);
			flg_d.v12 = (adc_s_q <= loop_fault_pkg::VLOW_12V_CODE);
		end
		adc_d = (ctl_q.adc_en && adc_stable) ? adc_s_q : adc_q;
		// Direction latched at fault onset so it cannot flip mid-alarm
		dir_d = (spi_timeout_i && !flg_q.spi_timeout) ? s_dir : dir_q;
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			ctl_q.alarm_spi_off <= loop_fault_pkg::CTL_ALARM_SPI_RST;
			ctl_q.adc_en        <= loop_fault_pkg::CTL_ADC_EN_RST;
			ctl_q.ref_pd        <= loop_fault_pkg::CTL_REF_PD_RST;
			ctl_q.vlow_alert_en <= loop_fault_pkg::CTL_VLOW_ALERT_RST;
			flg_q <= loop_fault_pkg::FLT_RST[15:8];
			adc_q <= loop_fault_pkg::FLT_RST[7:0];
			dir_q <= 1'b0;
		end else begin
			ctl_q <= ctl_d;
			flg_q <= flg_d;
			adc_q <= adc_d;
			dir_q <= dir_d;
		end
	end

	logic alert_d;
	always_comb begin
		alert_d = flg_q.spi_timeout | flg_q.frame_err | flg_q.over
			| flg_q.under | flg_q.t140
			| (flg_q.v6 & ctl_q.vlow_alert_en);
	end

	// fault_wr_i is deliberately unused: the register has no write path
	assign fault_status_o = {flg_q, adc_q};
	assign fault_alert_o  = alert_d;
	assign adc_en_o       = ctl_q.adc_en;
	assign ref_pd_o       = ctl_q.ref_pd;
	assign alarm_force_o  = flg_q.spi_timeout & ~ctl_q.alarm_spi_off;
	assign alarm_high_o   = dir_q;

	logic unused_wr;
	assign unused_wr = fault_wr_i ^ (^fault_wdata_i);

	a_adc_off_reset: assert property (
		$rose(rst_n) |-> !adc_en_o)
		else $error("ADC enabled at reset");
	a_adc_frozen: assert property (
		!ctl_q.adc_en |=> $stable(fault_status_o[9:0]))
		else $error("ADC field moved while disabled");
	a_ref_pd_reset: assert property (
		$rose(rst_n) |-> !ref_pd_o)
		else $error("Reference powered down at reset");
	a_ref_pd_follow: assert property (
		ctl_wr_i |=> ref_pd_o ==
		$past(ctl_wdata_i[loop_fault_pkg::CTL_REF_PD_BIT]))
		else $error("Ref power-down mismatch");
	a_vlow_alert: assert property (
		(flg_q.v6 && ctl_q.vlow_alert_en) |-> fault_alert_o)
		else $error("Low loop voltage alert missing");
	a_v6_clear: assert property (
		(ctl_q.adc_en && adc_stable
		&& adc_s_q > loop_fault_pkg::VLOW_6V_CODE) |=> !flg_q.v6)
		else $error("Low loop voltage flag stuck");
	a_adc_track: assert property (
		(ctl_q.adc_en && adc_stable)
		|=> fault_status_o[7:0] == $past(adc_s_q))
		else $error("ADC field not updated");
	a_fault_ro: assert property (
		(fault_wr_i && !spi_timeout_i && !frame_check_error_i
		&& !valid_frame_i && !ctl_q.adc_en && $stable(async_s_q))
		|=> $stable(fault_status_o[15:14]) && $stable(fault_status_o[7:0]))
		else $error("Fault register changed by write");
	a_status_reset: assert property (
		$rose(rst_n) |-> fault_status_o == loop_fault_pkg::FLT_RST)
		else $error("Fault register not clear at reset");
	a_spi_flag: assert property (
		spi_timeout_i |=> fault_status_o[15] && fault_alert_o)
		else $error("SPI timeout not flagged");
	a_alarm_force: assert property (
		alarm_force_o == (fault_status_o[15] && !ctl_q.alarm_spi_off))
		else $error("Alarm forcing wrong");
	a_dir_sample: assert property (
		(spi_timeout_i && !flg_q.spi_timeout)
		|=> alarm_high_o == $past(s_dir))
		else $error("Alarm direction not taken from pin");
	a_frame_flag: assert property (
		frame_check_error_i |=> fault_status_o[14] ##0 fault_alert_o)
		else $error("Frame error not flagged");
	a_over_flag: assert property (
		$rose(over_i) ##1 over_i[*2] |=> fault_status_o[13])
		else $error("Over-current not flagged");
	a_under_flag: assert property (
		$rose(under_i) ##1 under_i[*2] |=> fault_status_o[12])
		else $error("Under-current not flagged");
	a_t140_set: assert property (
		s_h140 |=> flg_q.t140)
		else $error("Over-temp not flagged");
	a_t140_hold: assert property (
		(flg_q.t140 && !s_l125) |=> flg_q.t140)
		else $error("Over-temp cleared early");
	a_alarm_off: assert property (
		(flg_q.spi_timeout && ctl_q.alarm_spi_off)
		|-> fault_alert_o && !alarm_force_o)
		else $error("Alarm forced while disabled");
	a_alert_or: assert property (
		(|fault_status_o[15:11]) |-> fault_alert_o)
		else $error("Fault output missing");
	a_alert_quiet: assert property (
		(!(|fault_status_o[15:11])
		&& !(fault_status_o[9] && ctl_q.vlow_alert_en)) |-> !fault_alert_o)
		else $error("Fault output without cause");
	c_spi_alarm: cover property (alarm_force_o);
	c_frame_err: cover property (fault_status_o[14]);
	c_vlow: cover property (flg_q.v6 && fault_alert_o);
	c_t140: cover property (flg_q.t140 && fault_alert_o);
	c_fault_wr: cover property (fault_wr_i && !ctl_q.adc_en);
endmodule
`default_nettype wire

// >>> hw/loop_fault_pkg.sv
`default_nettype none
package loop_fault_pkg;
	// Control register bits held by this block
	localparam int CTL_ALARM_SPI_BIT = 10;
	localparam int CTL_ADC_EN_BIT    = 8;
	localparam int CTL_REF_PD_BIT    = 7;
	localparam int CTL_VLOW_ALERT_BIT = 6;
	localparam logic CTL_ALARM_SPI_RST  = 1'b0;
	localparam logic CTL_ADC_EN_RST     = 1'b0;
	localparam logic CTL_REF_PD_RST     = 1'b0;
	localparam logic CTL_VLOW_ALERT_RST = 1'b0;
	// Fault register layout
	localparam int FLT_SPI_BIT   = 15;
	localparam int FLT_FRAME_BIT = 14;
	localparam int FLT_OVER_BIT  = 13;
	localparam int FLT_UNDER_BIT = 12;
	localparam int FLT_T140_BIT  = 11;
	localparam int FLT_T100_BIT  = 10;
	localparam int FLT_V6_BIT    = 9;
	localparam int FLT_V12_BIT   = 8;
	localparam int FLT_ADC_MSB   = 7;
	localparam logic [15:0] FLT_RST = 16'h0000;
	// Loop sense: code = V * 256 / 2.5, thresholds in ADC codes
	localparam logic [7:0] VLOW_6V_CODE  = 8'h1F; // about 0.3 V
	localparam logic [7:0] VLOW_12V_CODE = 8'h3D; // about 0.6 V
	typedef struct packed {
		logic spi_timeout;
		logic frame_err;
		logic over;
		logic under;
		logic t140;
		logic t100;
		logic v6;
		logic v12;
	} fault_flags_s;
	typedef struct packed {
		logic alarm_spi_off;
		logic adc_en;
		logic ref_pd;
		logic vlow_alert_en;
	} ctl_bits_s;
endpackage
`default_nettype wire

// >>> tb/frame_host.sv
`timescale 1ns/1ps
`default_nettype none
// Stands in for the frame decoder and watchdog
module frame_host (
	input  wire logic        mclk_i,
	output logic             ctl_wr_o,
	output logic             fault_wr_o,
	output logic [15:0]      wdata_o,
	output logic [2:0]       ev_o
);
	initial begin
		ctl_wr_o = 1'b0;
		fault_wr_o = 1'b0;
		wdata_o = 16'h0000;
		ev_o = 3'h0;
	end
	task automatic wr(input logic [15:0] w, input logic flt);
		@(posedge mclk_i);
		ctl_wr_o <= !flt;
		fault_wr_o <= flt;
		wdata_o <= w;
		@(posedge mclk_i);
		ctl_wr_o <= 1'b0;
		fault_wr_o <= 1'b0;
		// Stale word is not left on the bus
		wdata_o <= ~w;
	endtask
	// ev: {valid frame, check error, timeout}
	task automatic ev(input logic [2:0] e);
		@(posedge mclk_i);
		ev_o <= e;
		@(posedge mclk_i);
		ev_o <= 3'h0;
	endtask
endmodule
`default_nettype wire

// >>> tb/loop_dac_fault_status_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module loop_dac_fault_status_tb_top;
	logic        mclk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        ctl_wr, fault_wr, alert, alarm_force, high, adc_en, ref_pd;
	logic [15:0] wdata, status;
	logic [2:0]  ev;
	logic        over = 0, under = 0, hi140 = 0, lo125 = 1;
	logic        hi100 = 0, lo85 = 1, dir = 1;
	logic [7:0]  sense = 8'h1F;
	int          errors = 0;
	int          cmp_count = 0;
	wire  [15:0] outs = {11'h000, alert, alarm_force, high, adc_en, ref_pd};
	always #5 mclk_i = ~mclk_i;
	frame_host u_host (.mclk_i(mclk_i), .ctl_wr_o(ctl_wr),
		.fault_wr_o(fault_wr), .wdata_o(wdata), .ev_o(ev));
	loop_dac_fault_status u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.ctl_wr_i(ctl_wr), .ctl_wdata_i(wdata), .fault_wr_i(fault_wr),
		.fault_wdata_i(wdata), .spi_timeout_i(ev[0]),
		.frame_check_error_i(ev[1]), .valid_frame_i(ev[2]),
		.over_i(over), .under_i(under), .temp_hi140_i(hi140),
		.temp_lo125_i(lo125), .temp_hi100_i(hi100), .temp_lo85_i(lo85),
		.loop_sense_voltage_i(sense), .alarm_dir_i(dir),
		.fault_status_o(status), .fault_alert_o(alert),
		.adc_en_o(adc_en), .ref_pd_o(ref_pd),
		.alarm_force_o(alarm_force), .alarm_high_o(high));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Async inputs need two sync flops plus the register
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic give_verdict;
		$display("errors=%0d compares=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic t_ctl;
		u_host.wr(16'h0180, 1'b0);
		cyc(0);
		chk(outs, 16'h0003);
		// Let the ADC field settle, then freeze it before the write
		cyc(3);
		u_host.wr(16'h0000, 1'b0);
		cyc(0);
		chk(outs, 16'h0000);
		u_host.wr(16'hFFFF, 1'b1);
		cyc(1);
		chk(status, 16'h031F);
	endtask
	task automatic t_spi;
		u_host.ev(3'h1);
		cyc(0);
		chk(status, 16'h831F);
		chk(outs, 16'h001C);
		u_host.ev(3'h4);
		@(posedge mclk_i) dir <= 1'b0;
		u_host.wr(16'h0400, 1'b0);
		u_host.ev(3'h1);
		cyc(0);
		chk(outs, 16'h0010);
		u_host.ev(3'h2);
		cyc(0);
		chk(status, 16'hC31F);
		u_host.ev(3'h4);
		cyc(0);
		chk({status[15:14], 13'h0000, alert}, 16'h0000);
		u_host.wr(16'h0000, 1'b0);
	endtask
	task automatic t_levels;
		@(posedge mclk_i) over <= 1'b1;
		cyc(3);
		chk({status[15:8], 7'h00, alert}, 16'h2301);
		@(posedge mclk_i) over <= 1'b0;
		under <= 1'b1;
		cyc(3);
		chk({status[15:8], 7'h00, alert}, 16'h1301);
		@(posedge mclk_i) under <= 1'b0;
		hi140 <= 1'b1;
		lo125 <= 1'b0;
		cyc(3);
		chk({status[15:8], 7'h00, alert}, 16'h0B01);
		@(posedge mclk_i) hi140 <= 1'b0;
		cyc(3);
		chk(status, 16'h0B1F);
		@(posedge mclk_i) lo125 <= 1'b1;
		hi100 <= 1'b1;
		lo85 <= 1'b0;
		cyc(3);
		chk({status[15:8], 7'h00, alert}, 16'h0700);
		@(posedge mclk_i) hi100 <= 1'b0;
		lo85 <= 1'b1;
	endtask
	task automatic t_loop_sense_voltage;
		u_host.wr(16'h0100, 1'b0);
		cyc(3);
		chk(status, 16'h031F);
		chk(outs, 16'h0002);
		u_host.wr(16'h0140, 1'b0);
		cyc(0);
		chk(outs, 16'h0012);
		@(posedge mclk_i) sense <= 8'h80;
		// ADC word also waits for two equal synchronised samples
		cyc(4);
		chk(status, 16'h0080);
		chk({15'h0000, alert}, 16'h0000);
	endtask
	initial begin
		#200000;
		errors++;
		give_verdict();
	end
	initial begin
		repeat (10) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		cyc(1);
		chk(status, 16'h0000);
		chk(outs, 16'h0000);
		cyc(1);
		t_ctl();
		t_spi();
		t_levels();
		t_loop_sense_voltage();
		give_verdict();
	end
endmodule
`default_nettype wire
